// file: nbm_pkg.sv
// Shared constants and types for the nibble-bus memory and display chip.
// Assumes one core clock; all pin levels arrive already synchronous to it.
package nbm_pkg;

  typedef enum logic [1:0] {
    NBM_ST_CMD   = 2'b00,
    NBM_ST_ADDR  = 2'b01,
    NBM_ST_READ  = 2'b11,
    NBM_ST_WRITE = 2'b10
  } nbm_phase_t;

  typedef enum logic [1:0] {
    NBM_KIND_RAM  = 2'h0,
    NBM_KIND_ROM  = 2'h1,
    NBM_KIND_DISP = 2'h2
  } nbm_kind_t;

  // Command nibbles
  localparam logic [3:0] NBM_CMD_LOAD_PC  = 4'h1;
  localparam logic [3:0] NBM_CMD_LOAD_DP  = 4'h2;
  localparam logic [3:0] NBM_CMD_READ_PC  = 4'h3;
  localparam logic [3:0] NBM_CMD_READ_DP  = 4'h4;
  localparam logic [3:0] NBM_CMD_WRITE_DP = 4'h5;
  localparam logic [3:0] NBM_CMD_IDENT    = 4'h8;
  localparam logic [3:0] NBM_CMD_CONFIG   = 4'h9;
  localparam logic [3:0] NBM_CMD_UNCONFIG = 4'ha;
  localparam logic [3:0] NBM_CMD_RESET    = 4'hb;

  // Identify answers, values arbitrary
  localparam logic [3:0] NBM_ID_RAM  = 4'h1;
  localparam logic [3:0] NBM_ID_ROM  = 4'h2;
  localparam logic [3:0] NBM_ID_DISP = 4'h3;

  localparam logic [2:0]  NBM_ADDR_NIBBLES = 3'h5;
  localparam int          NBM_MEM_NIBBLES  = 2048;
  localparam logic [19:0] NBM_ROM_LAST     = 20'h1ffff;
  localparam logic [8:0]  NBM_DISP_BASE9   = 9'h1c0;

  // Local nibble offsets inside a display chip
  localparam logic [10:0] NBM_DOT_BASE     = 11'h400;
  localparam logic [10:0] NBM_CONTRAST_OFS = 11'h5f0;
  localparam logic [10:0] NBM_CONTROL_OFS  = 11'h5f1;
  localparam logic [10:0] NBM_TIMER_OFS    = 11'h5f8;
  localparam logic [10:0] NBM_TIMER_LAST   = 11'h5fd;
  localparam logic [5:0]  NBM_SCAN_LAST    = 6'h2f;

  // Display tick from crystal edges
  localparam int         NBM_XTAL_HZ  = 32768;
  localparam int         NBM_TICK_HZ  = 512;
  localparam logic [5:0] NBM_DIV_LAST = 6'(NBM_XTAL_HZ / NBM_TICK_HZ - 1);

  localparam logic [3:0]  NBM_CTRL_RST     = 4'h0;
  localparam logic [3:0]  NBM_CONTRAST_RST = 4'h0;
  localparam logic [23:0] NBM_TIMER_RST    = 24'h0;

  typedef struct packed {
    logic       nibble_clock_pulse_n;
    logic       command_data_select_n;
    logic [3:0] nibble_lines;
    logic       output_float;
  } nbm_pins_t;

  typedef struct packed {
    nbm_phase_t  phase;
    logic [3:0]  op;
    logic [2:0]  addr_cnt;
    logic [19:0] shift;
    logic [19:0] code_ptr;
    logic [19:0] data_ptr;
    logic        use_code;
    logic        configured;
    logic [8:0]  base;
    logic        str_q;
    logic        xtal_q;
    logic        tick_in_q;
    logic [5:0]  div;
    logic        tick;
    logic [23:0] timer;
    logic [3:0]  ctrl;
    logic [3:0]  contrast;
    logic [7:0]  blink_cnt;
    logic        blink_ph;
    logic [5:0]  scan;
    logic [3:0]  bus_out;
    logic        bus_oe;
    logic [7:0]  dot_byte;
    logic        disp_on;
    logic        svc;
    logic        wake;
    logic        chain_out;
  } nbm_state_t;

endpackage

// file: nbm_chip.sv
// Bus slave for one RAM, ROM or display chip on the four-bit nibble bus.
// Assumes strobe, command/data, crystal and chain levels are synchronous
// to core_clk_in; the testbench resolves the shared nibble wire.
// Contract
// - Each RAM chip holds 2048 four-bit nibbles.
// - Separate code pointer and data pointer in every memory chip.
// - Load-pointer command plus five nibbles loads the named pointer everywhere.
// - Only a chip whose range holds the pointer moves data.
// - Pointer increments after each transfer; further strobes stream nibbles.
// - RAM answers only identify until configured into the address map.
// - RAM contents survive light and deep sleep.
// - System ROM answers 0x00000 to 0x1ffff, never relocated.
// - Output-float input releases the four bus lines.
// - Identify and configure walk the daisy chain; unconfigure matches the address, reset clears every RAM chip.
// - Master display divides 32768 Hz crystal to a 512 Hz tick.
// - Master drives tick, display enable, reference; rows and columns split.
// - Dot lit when its display bit is one.
// - Display memory bytes map to row and column drivers.
// - Each display chip holds 512 bytes of user RAM.
// - Contrast nibble sets drive voltage, larger is darker.
// - Control bit 0 switches display; bits 0 and 1 blink.
// - Reads give battery flags; writes set test bit and timer enable.
// - 24-bit timer decrements every 1/512 second.
// - Master's timer MSB with enable raises service and wakes CPU.
// - Config-select pins pick display address and master or slave.
// - Commands latch on strobe rising edge while CD is low.
`timescale 1ns/1ps

module nbm_chip
  import nbm_pkg::*;
#(
  parameter nbm_kind_t KIND        = NBM_KIND_RAM,
  parameter int        MEM_NIBBLES = NBM_MEM_NIBBLES
) (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire nbm_pins_t  bus_pins_in,
  input  wire logic       chain_identify_in,
  input  wire logic [1:0] config_select_pins_in,
  input  wire logic       crystal_pins_in,
  input  wire logic       display_tick_in,
  input  wire logic       display_enable_line_in,
  input  wire logic       very_low_battery_flag_in,
  input  wire logic       low_battery_flag_in,
  input  wire logic       shutdown_in,
  output logic [3:0]      nibble_lines_out,
  output logic            nibble_lines_oe_out,
  output logic            chain_identify_out,
  output logic            command_data_pull_out,
  output logic            service_request_out,
  output logic            display_tick_out,
  output logic            display_enable_line_out,
  output logic [3:0]      contrast_out,
  output logic [5:0]      scan_index_out,
  output logic [7:0]      dot_byte_out
);

  localparam int AW = $clog2(MEM_NIBBLES);

  if (MEM_NIBBLES != (1 << AW) || MEM_NIBBLES > NBM_MEM_NIBBLES ||
      (KIND != NBM_KIND_ROM && MEM_NIBBLES != NBM_MEM_NIBBLES)) begin : g_chk
    $error("nbm_chip: MEM_NIBBLES must be 2048, or a smaller power of two for ROM");
  end

  nbm_state_t     s_reg;
  nbm_state_t     s_next;
  logic [3:0]     mem [MEM_NIBBLES];
  logic           wr_en;
  logic [AW-1:0]  wr_addr;
  logic [3:0]     wr_data;
  logic           str_rise;
  logic           cmd_evt;
  logic           dat_evt;
  logic           xtal_rise;
  logic           tick_evt;
  logic           master;
  logic           cfgd;
  logic           head;
  logic           sel;
  logic [19:0]    act_ptr;
  logic [19:0]    nxt_ptr;
  logic [19:0]    load_val;
  logic [8:0]     disp_base;
  logic [3:0]     nib;
  logic [10:0]    dot_addr;

  function automatic logic in_range(input logic [19:0] a, input logic c,
                                    input logic [8:0] b);
    if (KIND == NBM_KIND_ROM) begin
      return a <= NBM_ROM_LAST;
    end
    return c && (a[19:11] == b);
  endfunction

  function automatic logic [3:0] peek(input logic [19:0] a, input nbm_state_t st);
    logic [10:0] li;
    logic [2:0]  ti;
    li = a[10:0];
    ti = 3'(li - NBM_TIMER_OFS);
    if (KIND == NBM_KIND_DISP && li == NBM_CONTRAST_OFS) begin
      return st.contrast;
    end
    if (KIND == NBM_KIND_DISP && li == NBM_CONTROL_OFS) begin
      return {low_battery_flag_in, very_low_battery_flag_in, st.ctrl[1:0]};
    end
    if (KIND == NBM_KIND_DISP && li >= NBM_TIMER_OFS && li <= NBM_TIMER_LAST) begin
      return st.timer[ti*4 +: 4];
    end
    return mem[a[AW-1:0]];
  endfunction

  always_comb begin
    s_next    = s_reg;
    wr_en     = 1'b0;
    wr_addr   = '0;
    wr_data   = 4'h0;
    nib       = bus_pins_in.nibble_lines;
    master    = (KIND == NBM_KIND_DISP) && (config_select_pins_in == 2'h0);
    disp_base = NBM_DISP_BASE9 + {7'h0, config_select_pins_in};
    cfgd      = (KIND != NBM_KIND_RAM) || s_reg.configured;
    head      = chain_identify_in && !cfgd;
    str_rise  = bus_pins_in.nibble_clock_pulse_n && !s_reg.str_q;
    cmd_evt   = str_rise && !bus_pins_in.command_data_select_n;
    dat_evt   = str_rise && bus_pins_in.command_data_select_n;
    act_ptr   = s_reg.use_code ? s_reg.code_ptr : s_reg.data_ptr;
    sel       = in_range(act_ptr, cfgd,
                         (KIND == NBM_KIND_DISP) ? disp_base : s_reg.base);
    load_val  = {nib, s_reg.shift[19:4]};
    xtal_rise = crystal_pins_in && !s_reg.xtal_q;
    tick_evt  = master ? (xtal_rise && s_reg.div == NBM_DIV_LAST)
                       : (display_tick_in && !s_reg.tick_in_q);
    s_next.str_q     = bus_pins_in.nibble_clock_pulse_n;
    s_next.xtal_q    = crystal_pins_in;
    s_next.tick_in_q = display_tick_in;
    s_next.tick      = 1'b0;

    // Display timing
    if (KIND == NBM_KIND_DISP) begin
      if (master && xtal_rise) begin
        s_next.div = s_reg.div + 6'h1;
      end
      s_next.tick = master && xtal_rise && s_reg.div == NBM_DIV_LAST;
      if (tick_evt) begin
        s_next.timer     = s_reg.timer - 24'h1;
        s_next.blink_cnt = s_reg.blink_cnt + 8'h1;
        s_next.scan      = (s_reg.scan == NBM_SCAN_LAST) ? 6'h0 : s_reg.scan + 6'h1;
        if (s_reg.blink_cnt == 8'hff) begin
          s_next.blink_ph = !s_reg.blink_ph;
        end
      end
    end

    // Bus sequencing
    if (cmd_evt) begin
      s_next.op       = nib;
      s_next.addr_cnt = 3'h0;
      unique case (nib)
        NBM_CMD_LOAD_PC, NBM_CMD_LOAD_DP, NBM_CMD_CONFIG, NBM_CMD_UNCONFIG: begin
          s_next.phase = NBM_ST_ADDR;
        end
        NBM_CMD_READ_PC: begin
          s_next.phase    = NBM_ST_READ;
          s_next.use_code = 1'b1;
        end
        NBM_CMD_READ_DP: begin
          s_next.phase    = NBM_ST_READ;
          s_next.use_code = 1'b0;
        end
        NBM_CMD_WRITE_DP: begin
          s_next.phase    = NBM_ST_WRITE;
          s_next.use_code = 1'b0;
        end
        NBM_CMD_IDENT: begin
          s_next.phase = NBM_ST_READ;
        end
        NBM_CMD_RESET: begin
          s_next.phase      = NBM_ST_CMD;
          s_next.configured = 1'b0;
        end
        default: begin
          s_next.phase = NBM_ST_CMD;
        end
      endcase
    end else if (dat_evt) begin
      unique case (s_reg.phase)
        NBM_ST_ADDR: begin
          s_next.shift    = load_val;
          s_next.addr_cnt = s_reg.addr_cnt + 3'h1;
          if (s_reg.addr_cnt == NBM_ADDR_NIBBLES - 3'h1) begin
            s_next.phase = NBM_ST_CMD;
            if (s_reg.op == NBM_CMD_LOAD_PC) begin
              s_next.code_ptr = load_val;
            end
            if (s_reg.op == NBM_CMD_LOAD_DP) begin
              s_next.data_ptr = load_val;
            end
            if (s_reg.op == NBM_CMD_CONFIG && KIND == NBM_KIND_RAM && head) begin
              s_next.configured = 1'b1;
              s_next.base       = load_val[19:11];
            end
            if (s_reg.op == NBM_CMD_UNCONFIG && s_reg.base == load_val[19:11]) begin
              s_next.configured = 1'b0;
            end
          end
        end
        NBM_ST_READ, NBM_ST_WRITE: begin
          if (s_reg.op != NBM_CMD_IDENT) begin
            nxt_ptr = act_ptr + 20'h1;
            if (s_reg.use_code) begin
              s_next.code_ptr = nxt_ptr;
            end else begin
              s_next.data_ptr = nxt_ptr;
            end
          end
          if (s_reg.phase == NBM_ST_WRITE && sel && KIND != NBM_KIND_ROM) begin
            if (KIND == NBM_KIND_DISP && act_ptr[10:0] == NBM_CONTRAST_OFS) begin
              s_next.contrast = nib;
            end else if (KIND == NBM_KIND_DISP && act_ptr[10:0] == NBM_CONTROL_OFS) begin
              s_next.ctrl = nib;
            end else if (KIND == NBM_KIND_DISP && act_ptr[10:0] >= NBM_TIMER_OFS &&
                         act_ptr[10:0] <= NBM_TIMER_LAST) begin
              s_next.timer[3'(act_ptr[10:0] - NBM_TIMER_OFS)*4 +: 4] = nib;
            end else begin
              wr_en   = 1'b1;
              wr_addr = act_ptr[AW-1:0];
              wr_data = nib;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Registered bus answer
    nxt_ptr = s_next.use_code ? s_next.code_ptr : s_next.data_ptr;
    if (s_next.op == NBM_CMD_IDENT) begin
      s_next.bus_out = (KIND == NBM_KIND_RAM) ? NBM_ID_RAM :
                       (KIND == NBM_KIND_ROM) ? NBM_ID_ROM : NBM_ID_DISP;
      s_next.bus_oe  = (s_next.phase == NBM_ST_READ) && head &&
                       !bus_pins_in.output_float;
    end else begin
      s_next.bus_out = peek(nxt_ptr, s_reg);
      s_next.bus_oe  = (s_next.phase == NBM_ST_READ) && !bus_pins_in.output_float &&
                       in_range(nxt_ptr, (KIND != NBM_KIND_RAM) || s_next.configured,
                                (KIND == NBM_KIND_DISP) ? disp_base : s_next.base);
    end

    // Display outputs
    dot_addr = NBM_DOT_BASE + {4'h0, s_reg.scan, 1'b0};
    if (KIND == NBM_KIND_DISP) begin
      s_next.disp_on  = master ? (s_reg.ctrl[0] && (!s_reg.ctrl[1] || s_reg.blink_ph))
                               : display_enable_line_in;
      s_next.dot_byte = s_reg.disp_on ? {mem[AW'(dot_addr + 11'h1)], mem[AW'(dot_addr)]}
                                      : 8'h00;
      s_next.svc      = master && s_reg.timer[23] && s_reg.ctrl[3];
      s_next.wake     = s_next.svc && shutdown_in;
    end
    s_next.chain_out = chain_identify_in && cfgd;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_reg          <= '0;
      s_reg.phase    <= NBM_ST_CMD;
      s_reg.str_q    <= 1'b1;
      s_reg.ctrl     <= NBM_CTRL_RST;
      s_reg.contrast <= NBM_CONTRAST_RST;
      s_reg.timer    <= NBM_TIMER_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // No reset on the array so contents survive sleep and reset
  always_ff @(posedge core_clk_in) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign nibble_lines_out        = s_reg.bus_out;
  assign nibble_lines_oe_out     = s_reg.bus_oe;
  assign chain_identify_out      = s_reg.chain_out;
  assign command_data_pull_out   = s_reg.wake;
  assign service_request_out     = s_reg.svc;
  assign display_tick_out        = s_reg.tick;
  assign display_enable_line_out = s_reg.disp_on;
  assign contrast_out            = s_reg.contrast;
  assign scan_index_out          = s_reg.scan;
  assign dot_byte_out            = s_reg.dot_byte;

  float_release_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    bus_pins_in.output_float |=> !nibble_lines_oe_out)
    else $error("bus driven while floated");

  range_drive_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (nibble_lines_oe_out && s_reg.op != NBM_CMD_IDENT && s_reg.phase == NBM_ST_READ &&
     $stable(s_reg.code_ptr) && $stable(s_reg.data_ptr) && $stable(s_reg.use_code))
    |-> sel)
    else $error("driving outside own range");

  unconfig_quiet_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (KIND == NBM_KIND_RAM && !s_reg.configured && s_reg.op != NBM_CMD_IDENT)
    |-> !nibble_lines_oe_out)
    else $error("unconfigured ram drives bus");

  pointer_step_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (dat_evt && s_reg.phase == NBM_ST_READ && s_reg.op != NBM_CMD_IDENT)
    |=> (s_reg.use_code ? s_reg.code_ptr : s_reg.data_ptr) == $past(act_ptr) + 20'h1)
    else $error("pointer did not step");

  load_ptr_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (dat_evt && s_reg.phase == NBM_ST_ADDR && s_reg.addr_cnt == 3'h4 &&
     s_reg.op == NBM_CMD_LOAD_DP) |=> s_reg.data_ptr == $past(load_val) && s_reg.phase == NBM_ST_CMD)
    else $error("data pointer load wrong");

  tick_div_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    display_tick_out |-> $past(s_reg.div) == NBM_DIV_LAST && $past(xtal_rise) && s_reg.div == 6'h0)
    else $error("tick not at divide end");

  timer_step_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (KIND == NBM_KIND_DISP && tick_evt && !(dat_evt && s_reg.phase == NBM_ST_WRITE))
    |=> s_reg.timer == $past(s_reg.timer) - 24'h1)
    else $error("timer did not decrement");

  service_req_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    service_request_out |-> $past(s_reg.timer[23]) && $past(s_reg.ctrl[3]) && master)
    else $error("service without timer cause");

  display_on_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (master && display_enable_line_out) |-> $past(s_reg.ctrl[0]))
    else $error("display on without control bit");

endmodule

// file: nbm_cpu_model.sv
// CPU-side master of the nibble bus: strobe, command/data select and nibbles.
// Assumes the bench resolves the shared nibble wire from this drive enable.
`timescale 1ns/1ps

module nbm_cpu_model
  import nbm_pkg::*;
(
  input  wire logic       core_clk_in,
  output logic            str_n_out,
  output logic            cd_n_out,
  output logic [3:0]      nib_out,
  output logic            drive_out
);
  int stream_cnt = 0;

  initial begin
    str_n_out = 1'b1;
    cd_n_out  = 1'b1;
    nib_out   = 4'h0;
    drive_out = 1'b0;
  end

  // One strobe cycle; request held until the edge that takes the rise
  task automatic strobe(input logic cd_lvl, input logic [3:0] nib, input logic drv);
    if (cd_lvl == 1'b0) stream_cnt = 0;
    else stream_cnt++;
    if (stream_cnt <= 16) begin
      @(posedge core_clk_in);
      str_n_out <= 1'b0;
      cd_n_out  <= cd_lvl;
      nib_out   <= nib;
      drive_out <= drv;
      @(posedge core_clk_in);
      str_n_out <= 1'b1;
      @(posedge core_clk_in);
      drive_out <= 1'b0;
    end
  endtask

  // Command then five address nibbles, low nibble first
  task automatic load(input logic [3:0] cmd, input logic [19:0] addr);
    strobe(1'b0, cmd, 1'b1);
    for (int i = 0; i < 5; i++) begin
      strobe(1'b1, addr[4*i +: 4], 1'b1);
    end
  endtask
endmodule

// file: nbm_chip_tb_top.sv
// Self-checking bench: one RAM chip and one master display chip on the nibble bus.
// Assumes the CPU model drives strobe and command lines; the bench resolves the wire.
`timescale 1ns/1ps

module nbm_chip_tb_top
  import nbm_pkg::*;
;
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

  localparam logic [8:0] RAM_BASE = 9'h005;
  logic       core_clk_in = 1'b0;
  logic       nrst_in     = 1'b0;
  logic       float_r     = 1'b0;
  logic       chain_r     = 1'b0;
  logic       xtal_r      = 1'b0;
  logic       lb_r        = 1'b0;
  logic       vlb_r       = 1'b0;
  logic       shut_r      = 1'b0;
  logic [1:0] xcnt        = 2'h0;
  logic [3:0] last_bus    = 4'h0;
  logic       str_n, cd_n, drv, ram_oe, ram_chain, dsp_oe, dsp_tick, dsp_on;
  logic [3:0] cpu_nib, bus_w, ram_out, dsp_out, dsp_con, n, c;
  logic [10:0] ofs;
  logic [5:0] dsp_scan;
  logic [7:0] dsp_dot;
  logic       dsp_svc;
  logic       dsp_wake;
  logic [3:0] mem_exp [0:2047];
  nbm_pins_t  pins;
  int         failures = 0;
  int         n_tests  = 0;
  int         seed, i, k, cnt;

  // The master owns the lines while it drives a command or write nibble
  assign bus_w = drv ? cpu_nib : (ram_oe ? ram_out : (dsp_oe ? dsp_out : ~last_bus));
  assign pins  = '{str_n, cd_n, bus_w, float_r};

  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    last_bus <= bus_w;
    xcnt     <= xcnt + 2'h1;
    xtal_r   <= xcnt[1];
  end

  nbm_cpu_model u_cpu (.core_clk_in(core_clk_in), .str_n_out(str_n), .cd_n_out(cd_n),
    .nib_out(cpu_nib), .drive_out(drv));

  nbm_chip #(.KIND(NBM_KIND_RAM)) u_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .bus_pins_in(pins), .chain_identify_in(chain_r), .config_select_pins_in(2'b00),
    .crystal_pins_in(xtal_r), .display_tick_in(dsp_tick), .display_enable_line_in(1'b0),
    .very_low_battery_flag_in(vlb_r), .low_battery_flag_in(lb_r), .shutdown_in(shut_r),
    .nibble_lines_out(ram_out), .nibble_lines_oe_out(ram_oe),
    .chain_identify_out(ram_chain), .command_data_pull_out(), .service_request_out(),
    .display_tick_out(), .display_enable_line_out(), .contrast_out(),
    .scan_index_out(), .dot_byte_out());

  nbm_chip #(.KIND(NBM_KIND_DISP)) u_disp (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .bus_pins_in(pins), .chain_identify_in(chain_r), .config_select_pins_in(2'b00),
    .crystal_pins_in(xtal_r), .display_tick_in(1'b0), .display_enable_line_in(1'b0),
    .very_low_battery_flag_in(vlb_r), .low_battery_flag_in(lb_r), .shutdown_in(shut_r),
    .nibble_lines_out(dsp_out), .nibble_lines_oe_out(dsp_oe), .chain_identify_out(),
    .command_data_pull_out(dsp_wake), .service_request_out(dsp_svc),
    .display_tick_out(dsp_tick), .display_enable_line_out(dsp_on), .contrast_out(dsp_con),
    .scan_index_out(dsp_scan), .dot_byte_out(dsp_dot));

  task automatic peek;
    @(posedge core_clk_in);
    #1;
  endtask

  function automatic logic [3:0] exp_ctrl(input logic lb, input logic vlb,
                                          input logic blink, input logic on);
    return {lb, vlb, blink, on};
  endfunction

  task automatic give_verdict;
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    failures++;
    give_verdict();
  end

  initial begin
    seed = 32'h68e7;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    // Unconfigured RAM stays off the bus
    u_cpu.load(NBM_CMD_LOAD_DP, {RAM_BASE, 11'h000});
    u_cpu.strobe(1'b0, NBM_CMD_READ_DP, 1'b1);
    peek();
    `CHK("oe unconfigured", 1'b0, ram_oe)
    @(posedge core_clk_in);
    chain_r <= 1'b1;
    u_cpu.load(NBM_CMD_CONFIG, {RAM_BASE, 11'h000});
    peek();
    `CHK("chain out", 1'b1, ram_chain)
    // Random write streams of 16, read back from the same start
    for (k = 0; k < 3; k++) begin
      ofs = 11'($random(seed)) & 11'h7f0;
      if (k == 2) ofs = 11'h7f0;
      u_cpu.load(NBM_CMD_LOAD_DP, {RAM_BASE, ofs});
      u_cpu.strobe(1'b0, NBM_CMD_WRITE_DP, 1'b1);
      for (i = 0; i < 16; i++) begin
        n = 4'($random(seed));
        mem_exp[ofs + 11'(i)] = n;
        u_cpu.strobe(1'b1, n, 1'b1);
      end
      u_cpu.load(NBM_CMD_LOAD_DP, {RAM_BASE, ofs});
      u_cpu.strobe(1'b0, NBM_CMD_READ_DP, 1'b1);
      for (i = 0; i < 16; i++) begin
        peek();
        `CHK("oe in range", 1'b1, ram_oe)
        `CHK("stream nibble", mem_exp[ofs + 11'(i)], ram_out)
        if (i < 15) u_cpu.strobe(1'b1, 4'h0, 1'b0);
      end
    end
    // Code pointer independent of data pointer, contents kept in sleep
    @(posedge core_clk_in);
    shut_r <= 1'b1;
    u_cpu.load(NBM_CMD_LOAD_PC, {RAM_BASE, ofs});
    u_cpu.load(NBM_CMD_LOAD_DP, {RAM_BASE, ofs + 11'h5});
    u_cpu.strobe(1'b0, NBM_CMD_READ_PC, 1'b1);
    peek();
    `CHK("code pointer read", mem_exp[ofs], ram_out)
    // Out of range pointer and float input both release the lines
    u_cpu.load(NBM_CMD_LOAD_DP, {RAM_BASE + 9'h1, 11'h000});
    u_cpu.strobe(1'b0, NBM_CMD_READ_DP, 1'b1);
    peek();
    `CHK("oe out of range", 1'b0, ram_oe)
    u_cpu.load(NBM_CMD_LOAD_DP, {RAM_BASE, ofs});
    u_cpu.strobe(1'b0, NBM_CMD_READ_DP, 1'b1);
    @(posedge core_clk_in);
    float_r <= 1'b1;
    peek();
    peek();
    `CHK("oe floated", 1'b0, ram_oe)
    @(posedge core_clk_in);
    float_r <= 1'b0;
    // Display contrast and control nibbles, battery flags on read
    c = 4'($random(seed));
    lb_r <= 1'($random(seed));
    vlb_r <= 1'($random(seed));
    u_cpu.load(NBM_CMD_LOAD_DP, {NBM_DISP_BASE9, NBM_CONTRAST_OFS});
    u_cpu.strobe(1'b0, NBM_CMD_WRITE_DP, 1'b1);
    u_cpu.strobe(1'b1, c, 1'b1);
    u_cpu.strobe(1'b1, 4'h1, 1'b1);
    peek();
    `CHK("contrast", c, dsp_con)
    `CHK("display on", 1'b1, dsp_on)
    u_cpu.load(NBM_CMD_LOAD_DP, {NBM_DISP_BASE9, NBM_CONTROL_OFS});
    u_cpu.strobe(1'b0, NBM_CMD_READ_DP, 1'b1);
    peek();
    `CHK("control read", exp_ctrl(lb_r, vlb_r, 1'b0, 1'b1), dsp_out)
    // Unconfigure drops the RAM from the map
    u_cpu.load(NBM_CMD_UNCONFIG, {RAM_BASE, 11'h000});
    u_cpu.load(NBM_CMD_LOAD_DP, {RAM_BASE, ofs});
    u_cpu.strobe(1'b0, NBM_CMD_READ_DP, 1'b1);
    peek();
    `CHK("oe unconfigured again", 1'b0, ram_oe)
    `CHK("chain out cleared", 1'b0, ram_chain)
    // Identify answers only at the head of the chain; reset drops configuration
    u_cpu.strobe(1'b0, NBM_CMD_IDENT, 1'b1);
    peek();
    `CHK("ident oe", 1'b1, ram_oe)
    `CHK("ident code", NBM_ID_RAM, ram_out)
    u_cpu.load(NBM_CMD_CONFIG, {RAM_BASE, 11'h000});
    peek();
    `CHK("chain out reconfigured", 1'b1, ram_chain)
    u_cpu.strobe(1'b0, NBM_CMD_RESET, 1'b1);
    peek();
    peek();
    `CHK("chain out after reset", 1'b0, ram_chain)
    // Tick period: 64 crystal rises of 4 clocks each
    cnt = 0;
    while (dsp_tick !== 1'b1 && cnt < 600) begin
      peek();
      cnt++;
    end
    k = dsp_scan;
    cnt = 0;
    do begin
      peek();
      cnt++;
    end while (dsp_tick !== 1'b1 && cnt < 600);
    `CHK("tick period", (NBM_XTAL_HZ / NBM_TICK_HZ) * 4, cnt)
    `CHK("scan step", (k + 1) % (NBM_SCAN_LAST + 1), dsp_scan)
    // Dot byte of the current scan index, right after a tick
    n = 4'($random(seed));
    c = 4'($random(seed));
    u_cpu.load(NBM_CMD_LOAD_DP, {NBM_DISP_BASE9, NBM_DOT_BASE + {4'h0, dsp_scan, 1'b0}});
    u_cpu.strobe(1'b0, NBM_CMD_WRITE_DP, 1'b1);
    u_cpu.strobe(1'b1, n, 1'b1);
    u_cpu.strobe(1'b1, c, 1'b1);
    peek();
    peek();
    `CHK("dot byte", {c, n}, dsp_dot)
    // Timer MSB with enable raises service and wake; display off blanks dots
    `CHK("no service", 1'b0, dsp_svc)
    u_cpu.load(NBM_CMD_LOAD_DP, {NBM_DISP_BASE9, NBM_TIMER_LAST});
    u_cpu.strobe(1'b0, NBM_CMD_WRITE_DP, 1'b1);
    u_cpu.strobe(1'b1, 4'h8, 1'b1);
    u_cpu.load(NBM_CMD_LOAD_DP, {NBM_DISP_BASE9, NBM_CONTROL_OFS});
    u_cpu.strobe(1'b0, NBM_CMD_WRITE_DP, 1'b1);
    u_cpu.strobe(1'b1, 4'h8, 1'b1);
    peek();
    peek();
    `CHK("service", 1'b1, dsp_svc)
    `CHK("wake pull", 1'b1, dsp_wake)
    `CHK("dark when off", 8'h00, dsp_dot)
    give_verdict();
  end
endmodule
